/* rtl/tmr_core.sv */
`timescale 1ns/10ps
// ============================================================
// Timer core: events, FIFO, counter, final count and DMA control.
// Operation
// - overflow event when FIFO fills in capture mode or drains in PWM mode
// - DMA-done enable only on DMA instances
// - half event at four entries threshold
// - data event on capture or active end
// - cycle event on timeout or period end
// - flag stays until software writes one
// - DMA-done flag when buffer transfer completes
// - FIFO entry count readable, at most eight
// - live counter readable, 26 bits
// - final count meaning depends on mode
// - only low 26 final bits used
// - final count write clears live counter
// - FIFO port read pops, write pushes
// - address wraps to start or stops
// - DMA enable starts and stops transfers
// - clear-all empties FIFO, counter and flags
// - mode select picks input or output modes
// - DMA stop address exclusive, word aligned
module tmr_core #(
	parameter bit DMA_CAPABLE = 1'b1
) (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        reset_n,
	// Avalon-MM register slave.
	input  wire logic [tmr_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [31:0]                 avs_readdata,
	output logic                             avs_waitrequest,
	// Timer pin.
	input  wire logic                        tmr_pin_in,
	output logic                             tmr_pin_out,
	output logic                             tmr_pin_oe,
	// Interrupt request.
	output logic                             irq,
	// DMA memory port, word addressed by byte address.
	output logic                             dma_req,
	output logic                             dma_we,
	output logic      [tmr_pkg::DMA_W+1:0]   dma_addr,
	output logic      [31:0]                 dma_wdata,
	input  wire logic                        dma_ack,
	input  wire logic [31:0]                 dma_rdata
);
	import tmr_pkg::*;

	tmr_fifo_if ff ();
	tmr_fifo u_fifo (.clk(clk), .reset_n(reset_n), .f(ff));

	logic             wait_reg, wait_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic [7:0]       mode_reg, mode_next, dctl_reg, dctl_next;
	logic [EV_W-1:0]  ien_reg, ien_next, flag_reg, flag_next, ev, clr_mask;
	logic [CNT_W-1:0] final_reg, final_next, cnt_reg, cnt_next, duty_reg, duty_next;
	logic [3:0]       rep_reg, rep_next;
	logic [LVL_W-1:0] lvl_prev_reg;
	logic             half_prev_reg, irq_reg, pout_reg, pout_next, poe_reg, poe_next;
	logic             in_s1_reg, in_s2_reg, in_prev_reg;
	logic [DMA_W-1:0] beg_reg, beg_next, stop_reg, stop_next, now_reg, now_next, now_inc;
	logic             dreq_reg, dreq_next, dwe_reg, dwe_next, halt_reg, halt_next;
	logic [31:0]      dwd_reg, dwd_next;
	logic             acc, wr_acc, rd_acc, clr_all, cen, hit, period_end, half_cond;
	logic             dma_run, dma_push, dma_pop, cap_push, pwm_load, bus_push, bus_pop;
	tmr_mode_t        mode;

	// ============================================================
	// Bus handshake: a request waits one cycle, then is taken.
	assign acc    = (avs_read || avs_write) && !wait_reg;
	assign wr_acc = avs_write && !wait_reg;
	assign rd_acc = avs_read && !wait_reg;

	// Waitrequest drops for exactly one cycle; read data is latched beforehand.
	always_comb begin
		wait_next  = acc || !(avs_read || avs_write);
		rdata_next = rdata_reg;
		if (avs_read && wait_reg) begin
			unique case (avs_address)
				OFS_MODE:   rdata_next = {24'h0, mode_reg};
				OFS_IEN:    rdata_next = {27'h0, ien_reg};
				OFS_FLAG:   rdata_next = {27'h0, flag_reg};
				OFS_LEVEL:  rdata_next = {28'h0, ff.level};
				OFS_COUNT:  rdata_next = {6'h0, cnt_reg};
				OFS_FINAL:  rdata_next = {6'h0, final_reg};
				OFS_FIFO:   rdata_next = {6'h0, ff.rdata};
				OFS_DMACTL: rdata_next = {24'h0, dctl_reg};
				OFS_DMABEG: rdata_next = {17'h0, beg_reg, 2'b00};
				OFS_DMAEND: rdata_next = {17'h0, stop_reg, 2'b00};
				OFS_DMANOW: rdata_next = {17'h0, now_reg, 2'b00};
				default:    rdata_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
		end else begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	// ============================================================
	// Pin input synchroniser; edges are found from the second stage and its delayed copy.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			in_s1_reg   <= 1'b0;
			in_s2_reg   <= 1'b0;
			in_prev_reg <= 1'b0;
		end else begin
			in_s1_reg   <= tmr_pin_in;
			in_s2_reg   <= in_s1_reg;
			in_prev_reg <= in_s2_reg;
		end
	end

	// ============================================================
	// Mode decode: output enable picks PWM over plain timing.
	always_comb begin
		if (mode_reg[MB_IN]) begin
			mode = mode_reg[MB_SUB] ? TMR_COUNT : TMR_CAPTURE;
		end else begin
			mode = mode_reg[MB_OEN] ? TMR_PWM : TMR_TIMING;
		end
	end

	assign clr_all    = mode_reg[MB_CLR];
	assign cen        = mode_reg[MB_CEN] && !clr_all;
	assign hit        = tmr_edge_hit(mode_reg[MB_EDGE +: 2], in_s2_reg, in_prev_reg);
	// Final count sets period, PWM total or capture timeout alike.
	assign period_end = cen && mode != TMR_COUNT && cnt_reg == final_reg - 26'h1;
	assign half_cond  = (mode == TMR_CAPTURE) ? (ff.level >= HALF_LVL) : (ff.level < HALF_LVL);
	assign dma_run    = DMA_CAPABLE && dctl_reg[DB_ON] && !halt_reg;

	// ============================================================
	// FIFO traffic. DMA owns the data port while it runs, so a bus
	// push or pop is dropped then; this keeps one producer per side.
	assign cap_push = cen && mode == TMR_CAPTURE && hit;
	assign pwm_load = period_end && mode == TMR_PWM && tmr_rep_last(mode_reg[MB_EDGE +: 2], rep_reg);
	assign dma_push = dreq_reg && dma_ack && !dwe_reg;
	assign dma_pop  = dma_run && !dreq_reg && mode == TMR_CAPTURE && ff.level != 4'h0;
	assign bus_push = wr_acc && avs_address == OFS_FIFO && !dma_run && !cap_push && !dma_push;
	assign bus_pop  = rd_acc && avs_address == OFS_FIFO && !dma_run && !pwm_load;

	always_comb begin
		ff.clear = clr_all;
		ff.push  = cap_push || dma_push || bus_push;
		ff.pop   = pwm_load || dma_pop || bus_pop;
		if (cap_push) begin
			ff.wdata = cnt_reg;
		end else if (dma_push) begin
			ff.wdata = dma_rdata[CNT_W-1:0];
		end else begin
			ff.wdata = avs_writedata[CNT_W-1:0];
		end
	end

	// ============================================================
	// Hardware events of this cycle.
	always_comb begin
		ev = EV_RST;
		ev[EV_CYC] = period_end || (cen && mode == TMR_COUNT && hit && cnt_reg == final_reg);
		ev[EV_ACT] = cap_push ||
			(cen && mode == TMR_PWM && cnt_reg == duty_reg && duty_reg != 26'h0);
		ev[EV_HALF] = half_cond && !half_prev_reg;
		ev[EV_OVF] = (mode == TMR_CAPTURE && ff.level == FULL_LVL && lvl_prev_reg != FULL_LVL) ||
			(mode == TMR_PWM && ff.level == 4'h0 && lvl_prev_reg != 4'h0);
		ev[EV_DMA] = dreq_reg && dma_ack && now_inc == stop_reg;
		if (clr_all) begin
			ev = EV_RST;
		end
	end

	// ============================================================
	// Software registers and sticky flags.
	always_comb begin
		logic [31:0] m;
		m = 32'h0;
		mode_next  = mode_reg;
		ien_next   = ien_reg;
		final_next = final_reg;
		dctl_next  = dctl_reg;
		beg_next   = beg_reg;
		stop_next  = stop_reg;
		clr_mask   = EV_RST;
		if (wr_acc) begin
			unique case (avs_address)
				OFS_MODE: begin
					m = tmr_merge({24'h0, mode_reg}, avs_writedata, avs_byteenable);
					mode_next = m[7:0] & MODE_MASK;
				end
				OFS_IEN: begin
					m = tmr_merge({27'h0, ien_reg}, avs_writedata, avs_byteenable);
					ien_next = m[EV_W-1:0] & (DMA_CAPABLE ? IEN_MASK_ALL : IEN_MASK_NDM);
				end
				OFS_FLAG: begin
					clr_mask = avs_byteenable[0] ? avs_writedata[EV_W-1:0] : EV_RST;
				end
				OFS_FINAL: begin
					m = tmr_merge({6'h0, final_reg}, avs_writedata, avs_byteenable);
					final_next = m[CNT_W-1:0];
				end
				OFS_DMACTL: begin
					m = tmr_merge({24'h0, dctl_reg}, avs_writedata, avs_byteenable);
					dctl_next = DMA_CAPABLE ? (m[7:0] & DMACTL_MASK) : 8'h00;
				end
				OFS_DMABEG: begin
					m = tmr_merge({17'h0, beg_reg, 2'b00}, avs_writedata, avs_byteenable);
					beg_next = m[DMA_W+1:2];
				end
				OFS_DMAEND: begin
					m = tmr_merge({17'h0, stop_reg, 2'b00}, avs_writedata, avs_byteenable);
					stop_next = m[DMA_W+1:2];
				end
				default: begin
				end
			endcase
		end
		// Zero bits clear nothing and a same-cycle event survives.
		flag_next = clr_all ? EV_RST : ((flag_reg & ~clr_mask) | ev);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mode_reg      <= MODE_RST;
			ien_reg       <= EV_RST;
			flag_reg      <= EV_RST;
			final_reg     <= CNT_RST;
			dctl_reg      <= 8'h00;
			beg_reg       <= DMA_RST;
			stop_reg      <= DMA_RST;
			irq_reg       <= 1'b0;
			half_prev_reg <= 1'b0;
			lvl_prev_reg  <= 4'h0;
		end else begin
			mode_reg      <= mode_next;
			ien_reg       <= ien_next;
			flag_reg      <= flag_next;
			final_reg     <= final_next;
			dctl_reg      <= dctl_next;
			beg_reg       <= beg_next;
			stop_reg      <= stop_next;
			irq_reg       <= |(flag_reg & ien_reg);
			half_prev_reg <= half_cond;
			lvl_prev_reg  <= ff.level;
		end
	end

	// ============================================================
	// Counter, PWM duty and pin. Active level is high unless polarity is set.
	always_comb begin
		cnt_next  = cnt_reg;
		duty_next = duty_reg;
		rep_next  = rep_reg;
		if (clr_all || (wr_acc && avs_address == OFS_FINAL)) begin
			cnt_next = CNT_RST;
			rep_next = 4'h0;
		end else if (cen) begin
			unique case (mode)
				TMR_COUNT: begin
					if (hit) begin
						cnt_next = (cnt_reg == final_reg) ? CNT_RST : cnt_reg + 26'h1;
					end
				end
				TMR_CAPTURE: begin
					cnt_next = (hit || period_end) ? CNT_RST : cnt_reg + 26'h1;
				end
				TMR_TIMING, TMR_PWM: begin
					cnt_next = period_end ? CNT_RST : cnt_reg + 26'h1;
					if (period_end && mode == TMR_PWM) begin
						rep_next = pwm_load ? 4'h0 : rep_reg + 4'h1;
						if (pwm_load && ff.level != 4'h0) begin
							duty_next = ff.rdata;
						end
					end
				end
			endcase
		end
		poe_next  = mode == TMR_PWM;
		pout_next = (mode == TMR_PWM && cen && cnt_reg < duty_reg) ^ mode_reg[MB_SUB];
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cnt_reg  <= CNT_RST;
			duty_reg <= CNT_RST;
			rep_reg  <= 4'h0;
			pout_reg <= 1'b0;
			poe_reg  <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			duty_reg <= duty_next;
			rep_reg  <= rep_next;
			pout_reg <= pout_next;
			poe_reg  <= poe_next;
		end
	end

	// ============================================================
	// DMA engine: one word at a time; a started word always completes.
	assign now_inc = now_reg + 13'h1;

	always_comb begin
		dreq_next = dreq_reg;
		dwe_next  = dwe_reg;
		dwd_next  = dwd_reg;
		now_next  = now_reg;
		halt_next = halt_reg;
		if (wr_acc && (avs_address == OFS_DMACTL || avs_address == OFS_DMABEG)) begin
			now_next  = beg_next;
			halt_next = 1'b0;
		end else if (dreq_reg) begin
			if (dma_ack) begin
				dreq_next = 1'b0;
				now_next  = now_inc;
				if (now_inc == stop_reg) begin
					now_next  = dctl_reg[DB_WRAP] ? beg_reg : now_inc;
					halt_next = !dctl_reg[DB_WRAP];
				end
			end
		end else if (dma_pop) begin
			dreq_next = 1'b1;
			dwe_next  = 1'b1;
			dwd_next  = {6'h0, ff.rdata};
		end else if (dma_run && mode == TMR_PWM && ff.level <= DMA_ROOM && !clr_all) begin
			dreq_next = 1'b1;
			dwe_next  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			dreq_reg <= 1'b0;
			dwe_reg  <= 1'b0;
			dwd_reg  <= 32'h0;
			now_reg  <= DMA_RST;
			halt_reg <= 1'b0;
		end else begin
			dreq_reg <= dreq_next;
			dwe_reg  <= dwe_next;
			dwd_reg  <= dwd_next;
			now_reg  <= now_next;
			halt_reg <= halt_next;
		end
	end

	// ============================================================
	// Outputs, all straight from flip-flops.
	assign avs_readdata    = rdata_reg;
	assign avs_waitrequest = wait_reg;
	assign tmr_pin_out     = pout_reg;
	assign tmr_pin_oe      = poe_reg;
	assign irq             = irq_reg;
	assign dma_req         = dreq_reg;
	assign dma_we          = dwe_reg;
	assign dma_addr        = {now_reg, 2'b00};
	assign dma_wdata       = dwd_reg;

	// ============================================================
	// Assertions.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_period_end;
		mode == TMR_TIMING && period_end && !(wr_acc && avs_address == OFS_FINAL);
	endsequence
	sequence s_wrap_done;
		dreq_reg && dma_ack && now_inc == stop_reg && dctl_reg[DB_WRAP] && !wr_acc && !clr_all;
	endsequence

	a_wait_one_low: assert property ((avs_read || avs_write) && wait_reg |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest not low for one cycle");
	a_flag_w1c: assert property (wr_acc && avs_address == OFS_FLAG && !clr_all |=>
		(flag_reg & $past(clr_mask) & ~$past(ev)) == 5'h0) else $error("flag not cleared by one");
	a_set_wins: assert property (|ev |=> (flag_reg & $past(ev)) == $past(ev))
		else $error("event lost against clear");
	a_irq_gate: assert property (|(flag_reg & ien_reg) |=> irq)
		else $error("enabled flag gives no interrupt");
	a_clear_all: assert property (clr_all ##1 clr_all |-> cnt_reg == 26'h0 && ff.level == 4'h0 && flag_reg == 5'h0)
		else $error("clear-all not holding state clear");
	a_final_clear: assert property (wr_acc && avs_address == OFS_FINAL |=> cnt_reg == 26'h0)
		else $error("final write did not clear counter");
	a_level_max: assert property (ff.level <= FULL_LVL)
		else $error("FIFO level above eight");
	a_timing_end: assert property (s_period_end |=> cnt_reg == 26'h0 && flag_reg[EV_CYC])
		else $error("period end not handled");
	a_dma_wrap: assert property (s_wrap_done |=> now_reg == $past(beg_reg) && flag_reg[EV_DMA])
		else $error("DMA address did not wrap");
	a_half_rise: assert property (half_cond && !half_prev_reg && !clr_all |=> flag_reg[EV_HALF])
		else $error("half event missed");
endmodule

/* rtl/tmr_pkg.sv */
// ============================================================
// Shared constants, types and helpers of the timer block.
package tmr_pkg;
	localparam int CNT_W      = 26;
	localparam int FIFO_DEPTH = 8;
	localparam int LVL_W      = 4;
	localparam int PTR_W      = 3;
	localparam int DMA_W      = 13;
	localparam int ADDR_W     = 6;
	localparam int EV_W       = 5;

	// Byte offsets of the word registers.
	localparam logic [ADDR_W-1:0] OFS_MODE   = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_IEN    = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_FLAG   = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_LEVEL  = 6'h0c;
	localparam logic [ADDR_W-1:0] OFS_COUNT  = 6'h10;
	localparam logic [ADDR_W-1:0] OFS_FINAL  = 6'h14;
	localparam logic [ADDR_W-1:0] OFS_FIFO   = 6'h18;
	localparam logic [ADDR_W-1:0] OFS_DMACTL = 6'h1c;
	localparam logic [ADDR_W-1:0] OFS_DMABEG = 6'h20;
	localparam logic [ADDR_W-1:0] OFS_DMAEND = 6'h24;
	localparam logic [ADDR_W-1:0] OFS_DMANOW = 6'h28;

	// Event bit positions, shared by enable and flag registers.
	localparam int EV_CYC  = 0;
	localparam int EV_ACT  = 1;
	localparam int EV_HALF = 2;
	localparam int EV_DMA  = 3;
	localparam int EV_OVF  = 4;

	// Mode register fields.
	localparam int MB_IN   = 0;
	localparam int MB_CLR  = 1;
	localparam int MB_CEN  = 2;
	localparam int MB_OEN  = 3;
	localparam int MB_SUB  = 4;
	localparam int MB_EDGE = 6;

	// DMA control fields.
	localparam int DB_ON   = 0;
	localparam int DB_WRAP = 2;

	// Reset values and writable masks.
	localparam logic [7:0]       MODE_RST     = 8'h02;
	localparam logic [7:0]       MODE_MASK    = 8'hdf;
	localparam logic [7:0]       DMACTL_MASK  = 8'h05;
	localparam logic [EV_W-1:0]  IEN_MASK_ALL = 5'h1f;
	localparam logic [EV_W-1:0]  IEN_MASK_NDM = 5'h17;
	localparam logic [EV_W-1:0]  EV_RST       = 5'h00;
	localparam logic [CNT_W-1:0] CNT_RST      = 26'h0000000;
	localparam logic [DMA_W-1:0] DMA_RST      = 13'h0000;
	localparam logic [LVL_W-1:0] HALF_LVL     = 4'h4;
	localparam logic [LVL_W-1:0] FULL_LVL     = 4'h8;
	localparam logic [LVL_W-1:0] DMA_ROOM     = 4'h6;

	typedef enum logic [1:0] {TMR_TIMING, TMR_PWM, TMR_CAPTURE, TMR_COUNT} tmr_mode_t;

	// Byte-lane merge of a 32-bit register write.
	function automatic logic [31:0] tmr_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Edge selection: 01 any edge, 10 falling, 11 rising, 00 none.
	function automatic logic tmr_edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
		return (sel == 2'b01 && cur != prev) || (sel == 2'b10 && prev && !cur) ||
			(sel == 2'b11 && !prev && cur);
	endfunction

	// Last pass of a repeated duty value: 1, 4, 8 or 16 passes.
	function automatic logic tmr_rep_last(input logic [1:0] sel, input logic [3:0] rep);
		return (sel == 2'b00) || (sel == 2'b01 && rep == 4'h3) || (sel == 2'b10 && rep == 4'h7) ||
			(sel == 2'b11 && rep == 4'hf);
	endfunction
endpackage

/* rtl/tmr_fifo_if.sv */
`timescale 1ns/10ps
// ============================================================
// Link between the timer core and its data FIFO.
interface tmr_fifo_if;
	import tmr_pkg::*;
	logic             clear;
	logic             push;
	logic             pop;
	logic [CNT_W-1:0] wdata;
	logic [CNT_W-1:0] rdata;
	logic [LVL_W-1:0] level;
	modport owner (output clear, push, pop, wdata, input rdata, level);
	modport store (input clear, push, pop, wdata, output rdata, level);
endinterface

/* rtl/tmr_fifo.sv */
`timescale 1ns/10ps
// ============================================================
// Eight-entry data FIFO held in flip-flops.
module tmr_fifo (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Core side.
	tmr_fifo_if.store f
);
	import tmr_pkg::*;

	logic [CNT_W-1:0] mem_reg [FIFO_DEPTH];
	logic [CNT_W-1:0] mem_next [FIFO_DEPTH];
	logic [PTR_W-1:0] rd_reg, rd_next, wr_reg, wr_next;
	logic [LVL_W-1:0] lvl_reg, lvl_next;
	logic             do_push, do_pop;

	// A push into a full store or a pop from an empty one is ignored.
	always_comb begin
		do_push = f.push && lvl_reg != FULL_LVL;
		do_pop  = f.pop && lvl_reg != 4'h0;
		mem_next = mem_reg;
		rd_next  = rd_reg;
		wr_next  = wr_reg;
		lvl_next = lvl_reg;
		if (f.clear) begin
			rd_next  = 3'h0;
			wr_next  = 3'h0;
			lvl_next = 4'h0;
		end else begin
			if (do_push) begin
				mem_next[wr_reg] = f.wdata;
				wr_next = wr_reg + 3'h1;
			end
			if (do_pop) begin
				rd_next = rd_reg + 3'h1;
			end
			lvl_next = lvl_reg + {3'h0, do_push} - {3'h0, do_pop};
		end
	end

	// State registers; data words need no reset.
	always_ff @(posedge clk) begin
		mem_reg <= mem_next;
		if (!reset_n) begin
			rd_reg  <= 3'h0;
			wr_reg  <= 3'h0;
			lvl_reg <= 4'h0;
		end else begin
			rd_reg  <= rd_next;
			wr_reg  <= wr_next;
			lvl_reg <= lvl_next;
		end
	end

	assign f.rdata = mem_reg[rd_reg];
	assign f.level = lvl_reg;
endmodule

/* dv/tmr_far_model.sv */
`timescale 1ns/10ps
// ====
// Far side: timer pin driver and DMA memory responder.
module tmr_far_model (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Pin side.
	input  wire logic        tog_en,
	output logic             pin,
	// DMA memory side.
	input  wire logic        dma_req,
	input  wire logic        dma_we,
	output logic             dma_ack,
	output logic      [31:0] dma_rdata,
	output int               n_wr
);
	int dly;
	// Start from a known pin level and pattern.
	initial begin
		pin = 1'b0;
		dly = 0;
		dma_rdata = 32'h0;
	end
	// Pin toggles every 8 cycles; acks wait 1 to 4 cycles so latency varies.
	always @(posedge clk) begin
		dly <= dly + 1;
		dma_rdata <= ~dma_rdata;
		if (tog_en && dly[2:0] == 3'h7) begin
			pin <= !pin;
		end
		if (!reset_n) begin
			dma_ack <= 1'b0;
			n_wr <= 0;
		end else if (dma_req && !dma_ack && dly[1:0] == 2'h3) begin
			dma_ack <= 1'b1;
			n_wr <= n_wr + int'(dma_we);
		end else begin
			dma_ack <= 1'b0;
		end
	end
endmodule

/* dv/timer_irq_fifo_dma_regs_tb_top.sv */
`timescale 1ns/10ps
// ====
// Register-level bench of the timer core.
module timer_irq_fifo_dma_regs_tb_top;
	import tmr_pkg::*;
	logic        clk, reset_n, rd, wr, tog, pin, irq, req, we, ack, wt, pout, poe;
	logic [5:0]  adr;
	logic [31:0] wd, rdat, mrd, v, fifo_q[$];
	logic [63:0] cur, exq[$];
	int          n_mismatch, comparisons, seed, n_wr, hi;
	tmr_core uut (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt),
		.tmr_pin_in(pin), .tmr_pin_out(pout), .tmr_pin_oe(poe), .irq(irq), .dma_req(req), .dma_we(we),
		.dma_addr(), .dma_wdata(), .dma_ack(ack), .dma_rdata(mrd));
	tmr_far_model far (.clk(clk), .reset_n(reset_n), .tog_en(tog), .pin(pin), .dma_req(req),
		.dma_we(we), .dma_ack(ack), .dma_rdata(mrd), .n_wr(n_wr));
	// ====
	// Clock, comparison and closing.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task test_done;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Master holds each request until waitrequest is seen low; reads leave a note.
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [31:0] e);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		if (!w)
			exq.push_back({m, e});
		do @(posedge clk); while (wt !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task ww(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 32'h0, 32'h0);
	endtask
	task rr(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0, m, e);
	endtask
	// Oldest note is compared at the edge where read data is taken.
	always @(posedge clk) begin
		if (rd && wt === 1'b0) begin
			cur = exq.pop_front();
			chk("readdata", rdat & cur[63:32], cur[31:0]);
		end
	end
	// A hang counts as a mismatch.
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		test_done;
	end
	// ====
	// Main sequence.
	initial begin
		{reset_n, rd, wr, tog, adr, wd} = '0;
		{n_mismatch, comparisons} = '0;
		seed = 32'h1bdf;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		rr(OFS_MODE, 32'hff, 32'(MODE_RST));
		rr(OFS_FLAG, 32'hff, 32'h0);
		rr(OFS_LEVEL, 32'hff, 32'h0);
		rr(6'h3c, 32'hffffffff, 32'h0);
		ww(OFS_IEN, 32'hff);
		rr(OFS_IEN, 32'hff, 32'(IEN_MASK_ALL));
		ww(OFS_DMACTL, 32'hff);
		rr(OFS_DMACTL, 32'hff, 32'(DMACTL_MASK));
		ww(OFS_DMACTL, 32'h0);
		ww(OFS_IEN, 32'h1 << EV_CYC);
		// Timing mode with a short period, then stopped.
		ww(OFS_FINAL, 32'ha);
		ww(OFS_MODE, 32'h1 << MB_CEN);
		repeat (60) @(posedge clk);
		ww(OFS_MODE, 32'h0);
		rr(OFS_COUNT, 32'hfc000000, 32'h0);
		rr(OFS_FLAG, 32'h1, 32'h1);
		#1 chk("irq", irq, 32'h1);
		ww(OFS_FLAG, 32'h0);
		rr(OFS_FLAG, 32'h1, 32'h1);
		ww(OFS_FLAG, 32'h1);
		rr(OFS_FLAG, 32'h1, 32'h0);
		ww(OFS_FINAL, 32'ha);
		rr(OFS_COUNT, 32'hffffffff, 32'h0);
		#1 chk("irq", irq, 32'h0);
		// Fill past full with random words, then drain in order.
		for (int i = 0; i < 9; i++) begin
			v = $random(seed);
			fifo_q.push_back(v & 32'h03ffffff);
			ww(OFS_FIFO, v);
		end
		rr(OFS_LEVEL, 32'hff, 32'(FULL_LVL));
		for (int i = 0; i < 8; i++)
			rr(OFS_FIFO, 32'hffffffff, fifo_q[i]);
		rr(OFS_LEVEL, 32'hff, 32'h0);
		ww(OFS_FIFO, 32'h5);
		ww(OFS_MODE, 32'h1 << MB_CLR);
		rr(OFS_LEVEL, 32'hff, 32'h0);
		rr(OFS_FLAG, 32'h1f, 32'h0);
		// PWM with duty 3 in a period of 8; the window spans whole periods.
		ww(OFS_FINAL, 32'h8);
		ww(OFS_MODE, 32'h0);
		ww(OFS_FIFO, 32'h3);
		ww(OFS_MODE, (32'h1 << MB_OEN) | (32'h1 << MB_CEN));
		repeat (20) @(posedge clk);
		hi = 0;
		repeat (80) begin
			@(posedge clk);
			if (pout === 1'b1)
				hi++;
		end
		chk("pwm high cycles", hi, 32'h1e);
		#1 chk("pin oe", poe, 32'h1);
		ww(OFS_MODE, 32'h0);
		rr(OFS_FLAG, 32'h17, 32'h13);
		ww(OFS_MODE, 32'h1 << MB_CLR);
		// Capture rising edges while the DMA stores two words and halts.
		ww(OFS_DMABEG, 32'h0);
		ww(OFS_DMAEND, 32'h8);
		ww(OFS_DMACTL, 32'h1 << DB_ON);
		ww(OFS_FINAL, 32'h03ffffff);
		ww(OFS_MODE, (32'h3 << MB_EDGE) | (32'h1 << MB_CEN) | (32'h1 << MB_IN));
		tog <= 1'b1;
		repeat (300) @(posedge clk);
		tog <= 1'b0;
		rr(OFS_FLAG, 32'h1e, 32'h1e);
		chk("dma words", n_wr, 32'h2);
		rr(OFS_LEVEL, 32'hff, 32'(FULL_LVL));
		// Wrapping DMA keeps draining captures into the two-word buffer.
		ww(OFS_MODE, 32'h1 << MB_CLR);
		ww(OFS_DMACTL, (32'h1 << DB_ON) | (32'h1 << DB_WRAP));
		ww(OFS_MODE, (32'h3 << MB_EDGE) | (32'h1 << MB_CEN) | (32'h1 << MB_IN));
		tog <= 1'b1;
		repeat (200) @(posedge clk);
		tog <= 1'b0;
		rr(OFS_FLAG, 32'h8, 32'h8);
		rr(OFS_DMANOW, 32'hfffffff8, 32'h0);
		rr(OFS_LEVEL, 32'hfc, 32'h0);
		ww(OFS_DMACTL, 32'h0);
		// Counting mode: four edges wanted, so software programs three.
		ww(OFS_MODE, 32'h1 << MB_CLR);
		ww(OFS_FINAL, 32'h3);
		ww(OFS_MODE, (32'h3 << MB_EDGE) | (32'h1 << MB_SUB) | (32'h1 << MB_CEN) | (32'h1 << MB_IN));
		tog <= 1'b1;
		repeat (120) @(posedge clk);
		tog <= 1'b0;
		rr(OFS_COUNT, 32'hfffffffc, 32'h0);
		rr(OFS_FLAG, 32'h1, 32'h1);
		test_done;
	end
endmodule
